// ### hw/fet_amp_regs_pkg.sv
// Purpose: constants for the fault-mask and sense-amplifier control registers
// Assumes: 16-bit register words carried by an already decoded serial frame
// Notes:   addresses are the frame's address byte
`default_nettype none
package fet_amp_regs_pkg;
    localparam logic [7:0]  FET_MASK_WR_ADDR  = 8'h30;
    localparam logic [7:0]  FET_MASK_RD_ADDR  = 8'hB0;
    localparam logic [7:0]  AMP_CTRL_WR_ADDR  = 8'h40;
    localparam logic [7:0]  AMP_CTRL_RD_ADDR  = 8'hC0;
    localparam logic [7:0]  CAL_CLR_WR_ADDR   = 8'h44;
    localparam logic [7:0]  CAL_STAT_RD_ADDR  = 8'hC4;
    localparam logic [15:0] FET_MASK_RESET    = 16'h0000;
    localparam logic [2:0]  GAIN_RESET        = 3'h3;
    localparam int          MASK_BITS         = 12;
    localparam int          PHASES            = 3;
    // phase u at index 2, v at 1, w at 0; each phase owns a nibble
    localparam int          U_NIBBLE_LSB      = 8;
    localparam int          V_NIBBLE_LSB      = 4;
    localparam int          W_NIBBLE_LSB      = 0;
    localparam int          CAL_TRIG_OFS      = 3;
    localparam int          CAL_BUSY_BIT      = 12;
    // all eight gain codes are defined settings; 101..111 give the same gain
    localparam logic [2:0]  GAIN_MAX_CODE     = 3'h7;
endpackage
`default_nettype wire

// ### hw/fet_fault_mask_and_amp_ctrl_regs.sv
// Purpose: fault-detection masks, amplifier gains and calibration triggers/status
// Assumes: frame decoder gives one strobe per frame with address byte and data
// Notes:   all outputs registered; trigger bits never stored
`default_nettype none
module fet_fault_mask_and_amp_ctrl_regs
    import fet_amp_regs_pkg::*;
(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // decoded serial frame
    input  wire logic                  frame_strobe,
    input  wire logic [7:0]            frame_addr,
    input  wire logic [15:0]           frame_wdata,
    output logic                       rd_valid,
    output logic      [15:0]           rd_data,
    // fault detection control
    output logic      [MASK_BITS-1:0]  det_enable,
    // amplifier control, index 2=u 1=v 0=w
    output logic      [3*PHASES-1:0]   amp_gain,
    output logic      [PHASES-1:0]     cal_start,
    input  wire logic [PHASES-1:0]     cal_done,
    input  wire logic [PHASES-1:0]     cal_result_pass,
    // calibration status
    output logic                       cal_busy
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic gain_code_defined(input logic [2:0] code);
        return code <= GAIN_MAX_CODE;
    endfunction

    function automatic int phase_lsb(input int p);
        return (p == 2) ? U_NIBBLE_LSB : (p == 1) ? V_NIBBLE_LSB : W_NIBBLE_LSB;
    endfunction

    function automatic logic frame_hits(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
        return strobe && (addr == target);
    endfunction

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // the read word and the nibble map only serve three 4-bit phase groups
    if (PHASES != 3) begin : g_bad_phase_count
        $error("phase nibble map serves exactly three phases");
    end
    if (MASK_BITS != 4 * PHASES) begin : g_bad_mask_bits
        $error("mask width must be four bits per phase");
    end
    if (U_NIBBLE_LSB + 4 > MASK_BITS || V_NIBBLE_LSB + 4 > U_NIBBLE_LSB || W_NIBBLE_LSB + 4 > V_NIBBLE_LSB) begin : g_bad_nibbles
        $error("phase nibbles must sit u over v over w without overlap");
    end
    if (CAL_TRIG_OFS != 3) begin : g_bad_trig_ofs
        $error("trigger bit must sit just above the 3-bit gain field");
    end
    if (CAL_BUSY_BIT < MASK_BITS || CAL_BUSY_BIT > 15) begin : g_bad_busy_bit
        $error("busy flag must sit above the nibbles of the read word");
    end
    if (GAIN_RESET > GAIN_MAX_CODE) begin : g_bad_gain_reset
        $error("reset gain must be a defined code");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [MASK_BITS-1:0]  fet_fault_detect_mask;
    logic [3*PHASES-1:0]   gain;
    logic [PHASES-1:0]     running;
    logic [PHASES-1:0]     pass;
    logic [MASK_BITS-1:0]  next_fet_fault_detect_mask;
    logic [3*PHASES-1:0]   next_gain;
    logic [PHASES-1:0]     next_running;
    logic [PHASES-1:0]     next_pass;
    logic [PHASES-1:0]     next_cal_start;
    logic                  next_rd_valid;
    logic [15:0]           next_rd_data;
    logic [MASK_BITS-1:0]  next_det_enable;
    logic                  next_cal_busy;

    // ----------------------------------------------------------------
    // configuration next state: masks and gains
    // ----------------------------------------------------------------
    always_comb begin
        logic       wr_mask;
        logic       wr_amp;
        logic [2:0] code;
        wr_mask = frame_hits(frame_strobe, frame_addr, FET_MASK_WR_ADDR);
        wr_amp  = frame_hits(frame_strobe, frame_addr, AMP_CTRL_WR_ADDR);
        code    = 3'h0;
        next_fet_fault_detect_mask = fet_fault_detect_mask;
        next_gain                  = gain;
        if (wr_mask) begin
            next_fet_fault_detect_mask = frame_wdata[MASK_BITS-1:0];
        end
        for (int p = 0; p < PHASES; p++) begin
            code = frame_wdata[phase_lsb(p) +: 3];
            if (wr_amp && gain_code_defined(code)) begin
                next_gain[3*p +: 3] = code;
            end
        end
        next_det_enable = ~next_fet_fault_detect_mask;
    end

    // ----------------------------------------------------------------
    // calibration next state: triggers, run flags and pass flags
    // ----------------------------------------------------------------
    always_comb begin
        logic wr_amp;
        logic wr_clr;
        wr_amp         = frame_hits(frame_strobe, frame_addr, AMP_CTRL_WR_ADDR);
        wr_clr         = frame_hits(frame_strobe, frame_addr, CAL_CLR_WR_ADDR);
        next_running   = running;
        next_pass      = pass;
        next_cal_start = '0;
        for (int p = 0; p < PHASES; p++) begin
            // a fresh trigger wins over a same-cycle completion and keeps the phase running
            if (wr_amp && frame_wdata[phase_lsb(p) + CAL_TRIG_OFS]) begin
                next_cal_start[p] = 1'b1;
                next_running[p]   = 1'b1;
            end else if (cal_done[p]) begin
                next_running[p]   = 1'b0;
            end
            // completion wins over a clear in the same cycle
            if (cal_done[p]) begin
                next_pass[p] = cal_result_pass[p];
            end else if (wr_clr && frame_wdata[phase_lsb(p)]) begin
                next_pass[p] = 1'b0;
            end
        end
        next_cal_busy = |next_running;
    end

    // ----------------------------------------------------------------
    // read path: answers one cycle after the strobe
    // ----------------------------------------------------------------
    always_comb begin
        next_rd_valid = 1'b0;
        next_rd_data  = 16'h0000;
        if (frame_strobe) begin
            case (frame_addr)
                FET_MASK_RD_ADDR: begin
                    next_rd_valid = 1'b1;
                    next_rd_data  = {4'h0, fet_fault_detect_mask};
                end
                AMP_CTRL_RD_ADDR: begin
                    next_rd_valid = 1'b1;
                    for (int p = 0; p < PHASES; p++) begin
                        next_rd_data[phase_lsb(p) +: 3] = gain[3*p +: 3];
                    end
                end
                CAL_STAT_RD_ADDR: begin
                    next_rd_valid = 1'b1;
                    next_rd_data[CAL_BUSY_BIT] = |running;
                    for (int p = 0; p < PHASES; p++) begin
                        next_rd_data[phase_lsb(p)] = pass[p];
                    end
                end
                default: begin
                    next_rd_valid = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fet_fault_detect_mask <= FET_MASK_RESET[MASK_BITS-1:0];
            gain                  <= {PHASES{GAIN_RESET}};
            det_enable            <= ~FET_MASK_RESET[MASK_BITS-1:0];
            amp_gain              <= {PHASES{GAIN_RESET}};
        end else begin
            fet_fault_detect_mask <= next_fet_fault_detect_mask;
            gain                  <= next_gain;
            det_enable            <= next_det_enable;
            amp_gain              <= next_gain;
        end
    end

    // ----------------------------------------------------------------
    // calibration registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            running   <= '0;
            pass      <= '0;
            cal_start <= '0;
            cal_busy  <= 1'b0;
        end else begin
            running   <= next_running;
            pass      <= next_pass;
            cal_start <= next_cal_start;
            cal_busy  <= next_cal_busy;
        end
    end

    // ----------------------------------------------------------------
    // read answer registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data  <= 16'h0000;
        end else begin
            rd_valid <= next_rd_valid;
            rd_data  <= next_rd_data;
        end
    end
endmodule // fet_fault_mask_and_amp_ctrl_regs
`default_nettype wire

// ### testbench/amp_cal_model.sv
// Purpose: calibration partner, answers a start after a delay
// Assumes: one start group in flight at a time
// Notes:   result follows pass_mode, inverted between answers
`default_nettype none
module amp_cal_model #(parameter int DELAY = 6) (
    input wire logic       sys_clk, rst,
    input wire logic [2:0] cal_start, pass_mode,
    output logic     [2:0] cal_done, cal_result_pass
);
    timeunit 1ns; timeprecision 1ns;
    logic [2:0] ph, next_ph;
    int         cnt, next_cnt;
    always_comb begin
        next_ph = cal_start != 3'h0 ? cal_start : ph;
        next_cnt = cal_start != 3'h0 ? DELAY : (cnt > 0 ? cnt - 1 : 0);
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        ph <= rst ? 3'h0 : next_ph;
        cnt <= rst ? 0 : next_cnt;
    end
    assign cal_done = cnt == 1 ? ph : 3'h0;
    assign cal_result_pass = cnt == 1 ? ph & pass_mode : ~pass_mode;
endmodule // amp_cal_model
`default_nettype wire

// ### testbench/fet_amp_regs_checker.sv
// Purpose: port checker for the mask and amplifier registers
// Assumes: single clock domain, reset active high
// Notes:   bound from the bench top
`default_nettype none
module fet_amp_regs_checker
    import fet_amp_regs_pkg::*;
(
    input wire logic        sys_clk, rst, frame_strobe, rd_valid, cal_busy,
    input wire logic [7:0]  frame_addr,
    input wire logic [15:0] frame_wdata, rd_data,
    input wire logic [11:0] det_enable,
    input wire logic [8:0]  amp_gain,
    input wire logic [2:0]  cal_start
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic        wm = frame_strobe && frame_addr == FET_MASK_WR_ADDR;
    wire logic        wa = frame_strobe && frame_addr == AMP_CTRL_WR_ADDR;
    wire logic [15:0] w  = frame_wdata;
    wire logic        rq = frame_strobe && (frame_addr[7:4] == 4'hB || frame_addr[7:4] == 4'hC);
    AST_MASK: assert property (wm |=> det_enable == ~$past(w[11:0]))
        else $error("mask write lost");
    AST_MASK_KEEP: assert property (!wm |=> $stable(det_enable))
        else $error("mask changed");
    AST_GAIN: assert property (wa |=> amp_gain == {$past(w[10:8]), $past(w[6:4]), $past(w[2:0])})
        else $error("gain write lost");
    AST_TRIG: assert property (wa |=> cal_start == {$past(w[11]), $past(w[7]), $past(w[3])})
        else $error("trigger wrong");
    AST_TRIG_CLR: assert property (cal_start != 3'h0 && !wa |=> cal_start == 3'h0)
        else $error("trigger stuck");
    AST_BUSY: assert property (cal_start != 3'h0 |-> cal_busy)
        else $error("busy low");
    AST_RD_MASK: assert property (frame_strobe && frame_addr == FET_MASK_RD_ADDR |=> rd_valid && rd_data == {4'h0, ~det_enable})
        else $error("mask read");
    AST_RD_AMP: assert property (frame_strobe && frame_addr == AMP_CTRL_RD_ADDR |=> rd_data == {5'h0, amp_gain[8:6], 1'b0, amp_gain[5:3], 1'b0, amp_gain[2:0]})
        else $error("amp read");
    AST_NO_RD: assert property (!rq |=> !rd_valid)
        else $error("stray read");
endmodule // fet_amp_regs_checker
`default_nettype wire

// ### testbench/tb.sv
// Purpose: register test of masks, gains and calibration
// Assumes: one decoded frame per strobe
// Notes:   calibration partner answers after a delay
`default_nettype none
module tb import fet_amp_regs_pkg::*;;
    timeunit 1ns; timeprecision 1ns;
    logic        sys_clk = 0, rst = 1, frame_strobe = 0, rd_valid, cal_busy;
    logic [7:0]  frame_addr = 8'h00;
    logic [15:0] frame_wdata = 16'h0000, rd_data, exp;
    logic [11:0] det_enable;
    logic [8:0]  amp_gain;
    logic [2:0]  cal_start, cal_done, cal_result_pass, pass_mode = 3'h0;
    int          miscompares = 0, samples_checked = 0, n;
    always #50 sys_clk = ~sys_clk;
    fet_fault_mask_and_amp_ctrl_regs u_dut (.sys_clk, .rst, .frame_strobe, .frame_addr, .frame_wdata, .rd_valid,
        .rd_data, .det_enable, .amp_gain, .cal_start, .cal_done, .cal_result_pass, .cal_busy);
    amp_cal_model u_cal (.sys_clk, .rst, .cal_start, .pass_mode, .cal_done, .cal_result_pass);
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        samples_checked++;
        if (got !== want) begin
            miscompares++;
            $display("ERROR %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        {frame_strobe, frame_addr, frame_wdata} <= {1'b1, a, d};
        @(posedge sys_clk);
        frame_strobe <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] want);
        xfer(a, 16'h0000);
        chk(rd_valid === 1'b1 ? rd_data : ~want, want);
    endtask
    task automatic check_defaults();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (11) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        chk({4'h0, det_enable}, 16'h0FFF);
        chk({7'h0, amp_gain}, 16'h00DB);
        chk({11'h0, rd_valid, cal_busy, cal_start}, 16'h0000);
        chk(rd_data, 16'h0000);
        rd(FET_MASK_RD_ADDR, 16'h0000);
        rd(AMP_CTRL_RD_ADDR, 16'h0333);
        rd(CAL_STAT_RD_ADDR, 16'h0000);
    endtask
    task automatic calibrate(input logic [15:0] d, input logic [15:0] busy_want, input logic [15:0] want);
        xfer(AMP_CTRL_WR_ADDR, d);
        chk({13'h0, cal_start}, {13'h0, d[11], d[7], d[3]});
        chk({15'h0, cal_busy}, 16'h0001);
        @(posedge sys_clk);
        #1;
        chk({13'h0, cal_start}, 16'h0000);
        rd(CAL_STAT_RD_ADDR, busy_want);
        for (n = 0; n < 20 && cal_busy !== 1'b0; n++) begin
            @(posedge sys_clk);
            #1;
        end
        if (n == 20) begin
            $display("ERROR %0t calibration never finished", $time);
            miscompares++;
            end_of_test();
        end
        rd(CAL_STAT_RD_ADDR, want);
        rd(AMP_CTRL_RD_ADDR, d & 16'h0777);
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        check_defaults();
        for (int i = 0; i < 12; i++) begin
            xfer(FET_MASK_WR_ADDR, 16'hF000 | (16'h0001 << i));
            chk({4'h0, det_enable}, 16'h0FFF ^ (16'h0001 << i));
            rd(FET_MASK_RD_ADDR, 16'h0001 << i);
        end
        for (int c = 0; c < 8; c++) begin
            exp = {5'h0, 3'(c), 1'b0, 3'(7 - c), 1'b0, 3'(c)};
            xfer(AMP_CTRL_WR_ADDR, exp | 16'hF000);
            chk({7'h0, amp_gain}, {7'h0, exp[10:8], exp[6:4], exp[2:0]});
            rd(AMP_CTRL_RD_ADDR, exp);
        end
        pass_mode <= 3'b101;
        calibrate(exp | 16'h0888, 16'h1000, 16'h0101);
        xfer(CAL_CLR_WR_ADDR, 16'h0100);
        rd(CAL_STAT_RD_ADDR, 16'h0001);
        pass_mode <= 3'b000;
        calibrate(exp | 16'h0800, 16'h1001, 16'h0001);
        check_defaults();
        xfer(8'h31, 16'hFFFF);
        chk({3'h0, rd_valid, det_enable}, 16'h0FFF);
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        $display("ERROR %0t run did not finish", $time);
        miscompares++;
        end_of_test();
    end
endmodule // tb
bind fet_fault_mask_and_amp_ctrl_regs fet_amp_regs_checker u_chk (.sys_clk, .rst, .frame_strobe, .frame_addr,
    .frame_wdata, .rd_valid, .rd_data, .det_enable, .amp_gain, .cal_start, .cal_busy);
`default_nettype wire
